/* File: pkg/node_cfg_params.svh */
/*
 Constants of the node configuration register bank: register numbers,
 field positions, reset values and widths. Assumes inclusion by the package.
*/
`ifndef NODE_CFG_PARAMS_SVH
`define NODE_CFG_PARAMS_SVH

`define REG_NUM_W          8
`define REG_IDENT          8'h00
`define REG_TOPO           8'h01
`define REG_LOCK_HDR       8'h04
`define REG_NODE_ID        8'h05
`define REG_PLL            8'h06
`define REG_SW_DIV         8'h07
`define REG_REF_DIV        8'h08
`define REG_SCAN_ID        8'h09
`define REG_USER_CODE      8'h0A
`define REG_DIR_LO         8'h0C
`define REG_DIR_HI         8'h0D
`define REG_SPARE_A        8'h10
`define REG_SPARE_B        8'h11

`define LOCK_CTL_BIT       31
`define LOCK_PLL_BIT       8
`define HDR_MODE_BIT       0
`define PLL_NORESET_BIT    31
`define PLL_NOWAIT_BIT     30
`define PLL_BYPASS_BIT     29
`define PLL_JTAGBOOT_BIT   28
`define PLL_OUTDIV_HI      25
`define PLL_OUTDIV_LO      23
`define PLL_F_HI           20
`define PLL_F_LO           8
`define PLL_R_HI           6
`define PLL_R_LO           0
`define PLL_WR_MASK        32'hF39F_FF7F
`define PLL_RESET_VAL      32'h0000_0000
`define REF_DIV_RESET      16'h0003
`define HALF_W             16
`define DIR_W              4
`define DIR_PER_TABLE      8
`define SPARE_MASK         32'h0000_0003
`define ZERO_WORD          32'h0000_0000

`endif

/* File: pkg/node_cfg_pkg.sv */
/*
 Types of the node configuration register bank.
 Assumes the constants header is on the include path.
*/
`include "node_cfg_params.svh"
package node_cfg_pkg;

	typedef logic [`REG_NUM_W-1:0] reg_num_t;

	// Configuration access as it arrives from the switch
	typedef struct packed {
		logic        valid;
		logic        write;
		reg_num_t    num;
		logic [31:0] wdata;
	} cfg_req_s;

	typedef struct packed {
		logic        valid;
		logic        ack;
		logic [31:0] rdata;
	} cfg_rsp_s;

	typedef struct packed {
		logic [`HALF_W-1:0] dest;
		logic               valid;
	} route_req_s;

	typedef struct packed {
		logic              valid;
		logic              local_hit;
		logic [`DIR_W-1:0] direction;
	} route_rsp_s;

	typedef struct packed {
		logic [7:0]          boot_pins;
		logic                boot_seen;
		logic                lock_ctl;
		logic                lock_pll;
		logic                hdr_one_byte;
		logic [`HALF_W-1:0]  node_id;
		logic [31:0]         pll;
		logic [`HALF_W-1:0]  sw_div;
		logic [`HALF_W-1:0]  ref_div;
		logic [31:0]         dir_lo;
		logic [31:0]         dir_hi;
		logic [1:0]          spare_a;
		logic [1:0]          spare_b;
		cfg_rsp_s            rsp;
		route_rsp_s          route;
		logic                tile_reset;
		logic                pll_wait_lock;
	} state_s;

endpackage : node_cfg_pkg

/* File: rtl/node_cfg_regs.sv */
/*
 Node configuration register bank of the packet switch: identity, lock,
 header mode, node identity, PLL and clock dividers, routing tables.
 Assumes configuration requests arrive synchronous to clk, one per cycle at most.
*/
// How it works
// - Identity bits 23:16 show boot pins caught after power-on reset, read-only.
// - Identity bits 15:8 revision, 7:0 version, read-only; 31:24 reserved.
// - Topology register reports link, switch processor and device processor counts.
// - Lock bit 31 set refuses writes to the switch control registers.
// - Lock bit 8 set refuses writes to the PLL settings register.
// - Config bit 0 selects one-byte headers; zero means two-byte headers.
// - Node identity is writable 16 bits, reset zero, upper half reads zero.
// - Any accepted PLL write pulses a tile reset unless suppressed.
// - PLL write with bit 31 set causes no reset.
// - PLL write with bit 30 set skips waiting for PLL re-lock.
// - PLL bit 29 set puts the PLL into bypass.
// - PLL bit 28 set forces boot from the JTAG port.
// - PLL bits 25:23 hold the output divider.
// - PLL bits 20:8 hold the feedback multiplication ratio.
// - PLL bits 6:0 hold the oscillator input divider.
// - Switch clock divider is 16 writable bits, reset zero.
// - Reference clock divider is 16 writable bits, reset three.
// - User-code register returns OTP code 31:18 and metal ID 17:0.
// - Low table holds directions for mismatch positions 0 to 7, nibble each.
// - High table holds directions for mismatch positions 8 to 15.
// - Route by highest bit where destination differs from node identity.
`timescale 1ns/1ns
`include "node_cfg_params.svh"
module node_cfg_regs #(
	parameter logic [7:0]  SWITCH_VERSION  = 8'h01, // Arbitrary value
	parameter logic [7:0]  SWITCH_REVISION = 8'h01, // Arbitrary value
	parameter logic [7:0]  LINK_COUNT      = 8'h08,
	parameter logic [7:0]  SW_PROC_COUNT   = 8'h01,
	parameter logic [7:0]  DEV_PROC_COUNT  = 8'h01,
	parameter logic [31:0] SCAN_IDENTITY   = 32'h0000_0001, // Arbitrary value
	parameter logic [13:0] OTP_USER_CODE   = 14'h0000,
	parameter logic [17:0] METAL_ID_CODE   = 18'h00000 // Arbitrary value
) (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    clk_en,
	input  wire logic [7:0]              boot_select_pins,
	input  wire node_cfg_pkg::cfg_req_s  cfg_req,
	output node_cfg_pkg::cfg_rsp_s       cfg_rsp,
	input  wire node_cfg_pkg::route_req_s route_req,
	output node_cfg_pkg::route_rsp_s     route_rsp,
	output logic                         header_one_byte,
	output logic [`HALF_W-1:0]           node_id,
	output logic [31:0]                  pll_control_register,
	output logic                         pll_bypass,
	output logic                         boot_from_jtag,
	output logic [2:0]                   pll_output_divider,
	output logic [12:0]                  pll_feedback_ratio,
	output logic [6:0]                   pll_input_divider,
	output logic                         pll_wait_lock,
	output logic                         tile_reset,
	output logic [`HALF_W-1:0]           switch_clock_div,
	output logic [`HALF_W-1:0]           reference_clock_div
);
	import node_cfg_pkg::*;

	state_s state_r;
	state_s state_nxt;

	logic [31:0]              rd_word;
	logic                     wr_ok;
	logic [`HALF_W-1:0]       diff;
	logic [`DIR_W*16-1:0]     dir_all;
	logic [4:0]               top_pos [0:16];

	assign dir_all = {state_r.dir_hi, state_r.dir_lo};
	assign diff    = route_req.dest ^ state_r.node_id;

	// Priority chain: higher positions override lower ones
	assign top_pos[0] = 5'h1F;
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_msb
			assign top_pos[g+1] = diff[g] ? 5'(g) : top_pos[g];
		end
	endgenerate

	// Read mux
	always_comb begin
		rd_word = `ZERO_WORD;
		if (cfg_req.num == `REG_IDENT) begin
			rd_word = {8'h00, state_r.boot_pins, SWITCH_REVISION, SWITCH_VERSION};
		end else if (cfg_req.num == `REG_TOPO) begin
			rd_word = {8'h00, LINK_COUNT, SW_PROC_COUNT, DEV_PROC_COUNT};
		end else if (cfg_req.num == `REG_LOCK_HDR) begin
			rd_word[`LOCK_CTL_BIT] = state_r.lock_ctl;
			rd_word[`LOCK_PLL_BIT] = state_r.lock_pll;
			rd_word[`HDR_MODE_BIT] = state_r.hdr_one_byte;
		end else if (cfg_req.num == `REG_NODE_ID) begin
			rd_word = {16'h0000, state_r.node_id};
		end else if (cfg_req.num == `REG_PLL) begin
			rd_word = state_r.pll;
		end else if (cfg_req.num == `REG_SW_DIV) begin
			rd_word = {16'h0000, state_r.sw_div};
		end else if (cfg_req.num == `REG_REF_DIV) begin
			rd_word = {16'h0000, state_r.ref_div};
		end else if (cfg_req.num == `REG_SCAN_ID) begin
			rd_word = SCAN_IDENTITY;
		end else if (cfg_req.num == `REG_USER_CODE) begin
			rd_word = {OTP_USER_CODE, METAL_ID_CODE};
		end else if (cfg_req.num == `REG_DIR_LO) begin
			rd_word = state_r.dir_lo;
		end else if (cfg_req.num == `REG_DIR_HI) begin
			rd_word = state_r.dir_hi;
		end else if (cfg_req.num == `REG_SPARE_A) begin
			rd_word = {30'h0000_0000, state_r.spare_a};
		end else if (cfg_req.num == `REG_SPARE_B) begin
			rd_word = {30'h0000_0000, state_r.spare_b};
		end
	end

	// Write permission: lock register itself stays writable, else it could never unlock
	always_comb begin
		wr_ok = 1'b1;
		if (cfg_req.num == `REG_PLL) begin
			wr_ok = !state_r.lock_pll;
		end else if (cfg_req.num != `REG_LOCK_HDR) begin
			wr_ok = !state_r.lock_ctl;
		end
	end

	always_comb begin
		state_nxt = state_r;
		state_nxt.rsp        = '0;
		state_nxt.route      = '0;
		state_nxt.tile_reset = 1'b0;
		// Strap caught once, at the first enabled edge after reset release
		if (!state_r.boot_seen) begin
			state_nxt.boot_pins = boot_select_pins;
			state_nxt.boot_seen = 1'b1;
		end
		if (cfg_req.valid) begin
			state_nxt.rsp.valid = 1'b1;
			state_nxt.rsp.ack   = !cfg_req.write || wr_ok;
			state_nxt.rsp.rdata = cfg_req.write ? `ZERO_WORD : rd_word;
		end
		if (cfg_req.valid && cfg_req.write && wr_ok) begin
			if (cfg_req.num == `REG_LOCK_HDR) begin
				state_nxt.lock_ctl     = cfg_req.wdata[`LOCK_CTL_BIT];
				state_nxt.lock_pll     = cfg_req.wdata[`LOCK_PLL_BIT];
				state_nxt.hdr_one_byte = cfg_req.wdata[`HDR_MODE_BIT];
			end else if (cfg_req.num == `REG_NODE_ID) begin
				state_nxt.node_id = cfg_req.wdata[`HALF_W-1:0];
			end else if (cfg_req.num == `REG_PLL) begin
				state_nxt.pll        = cfg_req.wdata & `PLL_WR_MASK;
				state_nxt.tile_reset = !cfg_req.wdata[`PLL_NORESET_BIT];
				state_nxt.pll_wait_lock = !cfg_req.wdata[`PLL_NOWAIT_BIT];
			end else if (cfg_req.num == `REG_SW_DIV) begin
				state_nxt.sw_div = cfg_req.wdata[`HALF_W-1:0];
			end else if (cfg_req.num == `REG_REF_DIV) begin
				state_nxt.ref_div = cfg_req.wdata[`HALF_W-1:0];
			end else if (cfg_req.num == `REG_DIR_LO) begin
				state_nxt.dir_lo = cfg_req.wdata;
			end else if (cfg_req.num == `REG_DIR_HI) begin
				state_nxt.dir_hi = cfg_req.wdata;
			end else if (cfg_req.num == `REG_SPARE_A) begin
				state_nxt.spare_a = cfg_req.wdata[1:0];
			end else if (cfg_req.num == `REG_SPARE_B) begin
				state_nxt.spare_b = cfg_req.wdata[1:0];
			end
		end
		if (route_req.valid) begin
			state_nxt.route.valid     = 1'b1;
			state_nxt.route.local_hit = (diff == 16'h0000);
			state_nxt.route.direction = (diff == 16'h0000) ? 4'h0 :
				dir_all[top_pos[16][3:0]*`DIR_W +: `DIR_W];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r         <= '0;
			state_r.pll     <= `PLL_RESET_VAL;
			state_r.ref_div <= `REF_DIV_RESET;
			state_r.pll_wait_lock <= 1'b1;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	assign cfg_rsp              = state_r.rsp;
	assign route_rsp            = state_r.route;
	assign header_one_byte      = state_r.hdr_one_byte;
	assign node_id              = state_r.node_id;
	assign pll_control_register = state_r.pll;
	assign pll_bypass           = state_r.pll[`PLL_BYPASS_BIT];
	assign boot_from_jtag       = state_r.pll[`PLL_JTAGBOOT_BIT];
	assign pll_output_divider   = state_r.pll[`PLL_OUTDIV_HI:`PLL_OUTDIV_LO];
	assign pll_feedback_ratio   = state_r.pll[`PLL_F_HI:`PLL_F_LO];
	assign pll_input_divider    = state_r.pll[`PLL_R_HI:`PLL_R_LO];
	assign pll_wait_lock        = state_r.pll_wait_lock;
	assign tile_reset           = state_r.tile_reset;
	assign switch_clock_div     = state_r.sw_div;
	assign reference_clock_div  = state_r.ref_div;

	// Assertions
	property p_lock_ctl;
		@(posedge clk) disable iff (!reset_n)
		clk_en && cfg_req.valid && cfg_req.write && state_r.lock_ctl
			&& cfg_req.num == `REG_NODE_ID |=> $stable(state_r.node_id) && !cfg_rsp.ack;
	endproperty
	a_lock_ctl: assert property (p_lock_ctl) else $error("locked write changed node id");

	property p_lock_pll;
		@(posedge clk) disable iff (!reset_n)
		clk_en && cfg_req.valid && cfg_req.write && state_r.lock_pll
			&& cfg_req.num == `REG_PLL |=> $stable(pll_control_register) && !tile_reset;
	endproperty
	a_lock_pll: assert property (p_lock_pll) else $error("locked PLL write took effect");

	sequence s_pll_wr(bit nr);
		clk_en && cfg_req.valid && cfg_req.write && cfg_req.num == `REG_PLL
			&& !state_r.lock_pll && cfg_req.wdata[`PLL_NORESET_BIT] == nr;
	endsequence

	property p_reset_on_pll;
		@(posedge clk) disable iff (!reset_n)
		s_pll_wr(1'b0) |=> tile_reset;
	endproperty
	a_reset_on_pll: assert property (p_reset_on_pll) else $error("PLL write gave no reset");

	property p_noreset;
		@(posedge clk) disable iff (!reset_n)
		s_pll_wr(1'b1) |=> !tile_reset;
	endproperty
	a_noreset: assert property (p_noreset) else $error("reset despite no-reset bit");

	property p_ident;
		@(posedge clk) disable iff (!reset_n)
		clk_en && cfg_req.valid && !cfg_req.write && cfg_req.num == `REG_IDENT
			|=> cfg_rsp.valid && cfg_rsp.rdata[7:0] == SWITCH_VERSION
			&& cfg_rsp.rdata[31:24] == 8'h00 && cfg_rsp.rdata[23:16] == state_r.boot_pins
			&& cfg_rsp.rdata[15:8] == SWITCH_REVISION;
	endproperty
	a_ident: assert property (p_ident) else $error("identity read wrong");

	property p_boot_hold;
		@(posedge clk) disable iff (!reset_n)
		state_r.boot_seen |=> $stable(state_r.boot_pins);
	endproperty
	a_boot_hold: assert property (p_boot_hold) else $error("boot pins changed");

	property p_local;
		@(posedge clk) disable iff (!reset_n)
		clk_en && route_req.valid && route_req.dest == node_id
			|=> route_rsp.valid && route_rsp.local_hit;
	endproperty
	a_local: assert property (p_local) else $error("matching dest not local");

	property p_route_top;
		@(posedge clk) disable iff (!reset_n)
		clk_en && route_req.valid && route_req.dest[15] != node_id[15]
			&& $stable(state_r.dir_hi)
			|=> route_rsp.direction == state_r.dir_hi[31:28] && !route_rsp.local_hit;
	endproperty
	a_route_top: assert property (p_route_top) else $error("bit 15 mismatch misrouted");

	property p_ref_reset;
		@(posedge clk) !reset_n |=> reference_clock_div == `REF_DIV_RESET;
	endproperty
	a_ref_reset: assert property (p_ref_reset) else $error("ref divider reset wrong");

	sequence s_pll_any;
		clk_en && cfg_req.valid && cfg_req.write && cfg_req.num == `REG_PLL
			&& !state_r.lock_pll;
	endsequence

	sequence s_ctl_wr(bit [`REG_NUM_W-1:0] r);
		clk_en && cfg_req.valid && cfg_req.write && cfg_req.num == r
			&& !state_r.lock_ctl;
	endsequence

	sequence s_rd(bit [`REG_NUM_W-1:0] r);
		clk_en && cfg_req.valid && !cfg_req.write && cfg_req.num == r;
	endsequence

	property p_topo;
		@(posedge clk) disable iff (!reset_n)
		s_rd(`REG_TOPO) |=> cfg_rsp.valid && cfg_rsp.ack
			&& cfg_rsp.rdata == {8'h00, LINK_COUNT, SW_PROC_COUNT, DEV_PROC_COUNT};
	endproperty
	a_topo: assert property (p_topo) else $error("topology read wrong");

	property p_user_code;
		@(posedge clk) disable iff (!reset_n)
		s_rd(`REG_USER_CODE) |=> cfg_rsp.valid
			&& cfg_rsp.rdata == {OTP_USER_CODE, METAL_ID_CODE};
	endproperty
	a_user_code: assert property (p_user_code) else $error("user code read wrong");

	property p_node_rd;
		@(posedge clk) disable iff (!reset_n)
		s_rd(`REG_NODE_ID) |=> cfg_rsp.rdata[31:16] == 16'h0000
			&& cfg_rsp.rdata[`HALF_W-1:0] == $past(node_id);
	endproperty
	a_node_rd: assert property (p_node_rd) else $error("node id read wrong");

	// Header mode sits in the lock register, which no lock can refuse
	property p_hdr_mode;
		@(posedge clk) disable iff (!reset_n)
		clk_en && cfg_req.valid && cfg_req.write && cfg_req.num == `REG_LOCK_HDR
			|=> header_one_byte == $past(cfg_req.wdata[`HDR_MODE_BIT]);
	endproperty
	a_hdr_mode: assert property (p_hdr_mode) else $error("header mode not taken");

	property p_node_wr;
		@(posedge clk) disable iff (!reset_n)
		s_ctl_wr(`REG_NODE_ID) |=> cfg_rsp.ack && node_id == $past(cfg_req.wdata[`HALF_W-1:0]);
	endproperty
	a_node_wr: assert property (p_node_wr) else $error("node id write lost");

	property p_lock_any;
		@(posedge clk) disable iff (!reset_n)
		clk_en && cfg_req.valid && cfg_req.write && state_r.lock_ctl
			&& cfg_req.num != `REG_LOCK_HDR && cfg_req.num != `REG_PLL
			|=> cfg_rsp.valid && !cfg_rsp.ack;
	endproperty
	a_lock_any: assert property (p_lock_any) else $error("locked write not refused");

	property p_wait_lock;
		@(posedge clk) disable iff (!reset_n)
		s_pll_any |=> pll_wait_lock == !$past(cfg_req.wdata[`PLL_NOWAIT_BIT]);
	endproperty
	a_wait_lock: assert property (p_wait_lock) else $error("re-lock wait wrong");

	property p_bypass;
		@(posedge clk) disable iff (!reset_n)
		s_pll_any |=> pll_bypass == $past(cfg_req.wdata[`PLL_BYPASS_BIT]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not taken");

	property p_jtag_boot;
		@(posedge clk) disable iff (!reset_n)
		s_pll_any |=> boot_from_jtag == $past(cfg_req.wdata[`PLL_JTAGBOOT_BIT]);
	endproperty
	a_jtag_boot: assert property (p_jtag_boot) else $error("boot source not taken");

	property p_out_div;
		@(posedge clk) disable iff (!reset_n)
		s_pll_any |=> pll_output_divider == $past(cfg_req.wdata[`PLL_OUTDIV_HI:`PLL_OUTDIV_LO]);
	endproperty
	a_out_div: assert property (p_out_div) else $error("output divider wrong");

	property p_feedback;
		@(posedge clk) disable iff (!reset_n)
		s_pll_any |=> pll_feedback_ratio == $past(cfg_req.wdata[`PLL_F_HI:`PLL_F_LO]);
	endproperty
	a_feedback: assert property (p_feedback) else $error("feedback ratio wrong");

	property p_in_div;
		@(posedge clk) disable iff (!reset_n)
		s_pll_any |=> pll_input_divider == $past(cfg_req.wdata[`PLL_R_HI:`PLL_R_LO]);
	endproperty
	a_in_div: assert property (p_in_div) else $error("input divider wrong");

	property p_sw_div;
		@(posedge clk) disable iff (!reset_n)
		s_ctl_wr(`REG_SW_DIV) |=> switch_clock_div == $past(cfg_req.wdata[`HALF_W-1:0]);
	endproperty
	a_sw_div: assert property (p_sw_div) else $error("switch divider write lost");

	property p_ref_div;
		@(posedge clk) disable iff (!reset_n)
		s_ctl_wr(`REG_REF_DIV) |=> reference_clock_div == $past(cfg_req.wdata[`HALF_W-1:0]);
	endproperty
	a_ref_div: assert property (p_ref_div) else $error("ref divider write lost");

	// Table read at the request edge; a write in that edge lands too late for it
	property p_route_pos7;
		@(posedge clk) disable iff (!reset_n)
		clk_en && route_req.valid && route_req.dest[15:8] == node_id[15:8]
			&& route_req.dest[7] != node_id[7]
			|=> route_rsp.direction == $past(state_r.dir_lo[31:28]);
	endproperty
	a_route_pos7: assert property (p_route_pos7) else $error("position 7 misrouted");

	property p_route_pos8;
		@(posedge clk) disable iff (!reset_n)
		clk_en && route_req.valid && route_req.dest[15:9] == node_id[15:9]
			&& route_req.dest[8] != node_id[8]
			|=> route_rsp.direction == $past(state_r.dir_hi[`DIR_W-1:0]);
	endproperty
	a_route_pos8: assert property (p_route_pos8) else $error("position 8 misrouted");

	property p_freeze;
		@(posedge clk) disable iff (!reset_n)
		!clk_en |=> $stable(state_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule : node_cfg_regs

/* File: tb/cfg_requester.sv */
/*
 Requester model for configuration reads and writes on the switch side.
 Assumes a free-running clk; drives its request only on falling edges.
*/
`timescale 1ns/1ns
module cfg_requester (
	input  wire logic                   clk,
	output node_cfg_pkg::cfg_req_s      cfg_req,
	input  wire node_cfg_pkg::cfg_rsp_s cfg_rsp
);
	import node_cfg_pkg::*;

	initial cfg_req = '{valid: 1'b0, write: 1'b0, num: 8'hFF, wdata: 32'hA5A5_A5A5};

	// One word per access, addressed by register number
	task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wd,
		output logic vld, output logic ack, output logic [31:0] rd);
		@(negedge clk);
		cfg_req <= '{valid: 1'b1, write: wr, num: num, wdata: wd};
		@(negedge clk);
		vld = cfg_rsp.valid;
		ack = cfg_rsp.ack;
		rd  = cfg_rsp.rdata;
		// Idle lines carry inverted leftovers so stale values cannot pass
		cfg_req <= '{valid: 1'b0, write: ~wr, num: ~num, wdata: ~wd};
	endtask : access
endmodule : cfg_requester

/* File: tb/test_switch_node_config_regs.sv */
/*
 Self-checking bench of the node configuration register bank with a model.
 Assumes the package and the requester model are compiled before it.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_switch_node_config_regs;
	import node_cfg_pkg::*;
	localparam logic [7:0]  VER   = 8'h3C; // Arbitrary value
	localparam logic [7:0]  REV   = 8'h5A; // Arbitrary value
	localparam logic [7:0]  LNK   = 8'h04;
	localparam logic [7:0]  SWP   = 8'h02;
	localparam logic [7:0]  DVP   = 8'h03;
	localparam logic [31:0] SCAN  = 32'h1234_5679; // Arbitrary value
	localparam logic [13:0] OTP   = 14'h2A5B;
	localparam logic [17:0] METAL = 18'h1C3D5; // Arbitrary value
	logic        clk     = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  pins    = 8'hC6;
	logic        ce      = 1'b1;
	route_req_s  route_req = '0;
	cfg_req_s    cfg_req;
	cfg_rsp_s    cfg_rsp;
	route_rsp_s  route_rsp;
	logic        hdr1, pby, pjt, pwl, trst, exp_wait, fv, fa;
	logic [15:0] nid, swd, rfd;
	logic [31:0] pllw, fq;
	logic [2:0]  pod;
	logic [12:0] pfr;
	logic [6:0]  pid;
	logic [7:0]  boot, n;
	logic [31:0] mdl [256];
	logic [7:0]  regs [14] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h0B};
	int          error_cnt = 0;
	int          n_tests   = 0;
	int          cyc       = 0;
	int          k;
	integer      seed      = 32'h1e5a8a1f;

	node_cfg_regs #(.SWITCH_VERSION(VER), .SWITCH_REVISION(REV), .LINK_COUNT(LNK),
		.SW_PROC_COUNT(SWP), .DEV_PROC_COUNT(DVP), .SCAN_IDENTITY(SCAN),
		.OTP_USER_CODE(OTP), .METAL_ID_CODE(METAL)) u_dut (
		.clk(clk), .reset_n(reset_n), .clk_en(ce), .boot_select_pins(pins),
		.cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .route_req(route_req),
		.route_rsp(route_rsp), .header_one_byte(hdr1), .node_id(nid),
		.pll_control_register(pllw), .pll_bypass(pby), .boot_from_jtag(pjt),
		.pll_output_divider(pod), .pll_feedback_ratio(pfr), .pll_input_divider(pid),
		.pll_wait_lock(pwl), .tile_reset(trst), .switch_clock_div(swd),
		.reference_clock_div(rfd));
	cfg_requester u_req (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

	always #4 clk = ~clk;

	task automatic results;
		if (error_cnt == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results

	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			results;
		end
	end

	function automatic logic [31:0] rd_exp(logic [7:0] r);
		case (r)
			8'h00: return {8'h00, boot, REV, VER};
			8'h01: return {8'h00, LNK, SWP, DVP};
			8'h09: return SCAN;
			8'h0A: return {OTP, METAL};
			default: return mdl[r];
		endcase
	endfunction : rd_exp

	task automatic check_outs;
		`CHK("header", mdl[4][0], hdr1)
		`CHK("node id", mdl[5][15:0], nid)
		`CHK("pll word", mdl[6], pllw)
		`CHK("bypass", mdl[6][29], pby)
		`CHK("jtag boot", mdl[6][28], pjt)
		`CHK("out div", mdl[6][25:23], pod)
		`CHK("feedback", mdl[6][20:8], pfr)
		`CHK("in div", mdl[6][6:0], pid)
		`CHK("wait lock", exp_wait, pwl)
		`CHK("sw div", mdl[7][15:0], swd)
		`CHK("ref div", mdl[8][15:0], rfd)
	endtask : check_outs

	task automatic rd(logic [7:0] r);
		logic v, a;
		logic [31:0] d;
		u_req.access(1'b0, r, 32'h0, v, a, d);
		`CHK("read", {2'b11, rd_exp(r)}, {v, a, d})
	endtask : rd

	task automatic wr(logic [7:0] r, logic [31:0] d);
		logic v, a, ok;
		logic [31:0] q;
		ok = (r == 8'h06) ? !mdl[4][8] : (r == 8'h04 || !mdl[4][31]);
		u_req.access(1'b1, r, d, v, a, q);
		`CHK("write ack", {1'b1, ok, 32'h0}, {v, a, q})
		`CHK("tile reset", ok && r == 8'h06 && !d[31], trst)
		if (ok) begin
			case (r)
				8'h04: mdl[r] = d & 32'h8000_0101;
				8'h05, 8'h07, 8'h08: mdl[r] = d & 32'h0000_FFFF;
				8'h06: begin
					// Reserved 27:26, 22:21 and 7 never stick
					mdl[r] = d & 32'hF39F_FF7F;
					exp_wait = !d[30];
				end
				8'h0C, 8'h0D: mdl[r] = d;
				8'h10, 8'h11: mdl[r] = d & 32'h0000_0003;
				default: ;
			endcase
		end
		check_outs;
	endtask : wr

	task automatic route(logic [15:0] dst);
		logic [15:0] x;
		logic [63:0] tbl;
		int p;
		x = dst ^ mdl[5][15:0];
		tbl = {mdl[8'h0D], mdl[8'h0C]};
		p = -1;
		for (int i = 0; i < 16; i++) if (x[i]) p = i;
		@(negedge clk);
		route_req <= '{dest: dst, valid: 1'b1};
		@(negedge clk);
		route_req <= '{dest: ~dst, valid: 1'b0};
		`CHK("route", {1'b1, p < 0, (p < 0) ? 4'h0 : tbl[4*p +: 4]}, route_rsp)
	endtask : route

	task automatic do_reset;
		@(negedge clk);
		reset_n = 1'b0;
		boot = pins;
		foreach (mdl[i]) mdl[i] = '0;
		mdl[8] = 32'h0000_0003;
		exp_wait = 1'b1;
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		// Straps move after capture; the identity word must not follow
		pins = 8'($random(seed));
		for (int r = 0; r < 8'h14; r++) rd(8'(r));
		check_outs;
	endtask : do_reset

	initial begin
		do_reset;
		repeat (400) begin
			k = {$random(seed)} % 16;
			n = (k < 14) ? regs[k] : 8'($random(seed));
			k = {$random(seed)} % 4;
			if (k < 2) wr(n, $random(seed));
			else if (k == 2) rd(n);
			else route(($random(seed) & 1) ? mdl[5][15:0] : 16'($random(seed)));
		end
		wr(8'h04, 32'h0);
		wr(8'h0C, $random(seed));
		wr(8'h0D, $random(seed));
		for (int p = 0; p < 16; p++) route(mdl[5][15:0] ^ (16'h1 << p));
		// Enable low: the request is lost and nothing moves
		@(negedge clk);
		ce = 1'b0;
		u_req.access(1'b1, 8'h05, ~mdl[5], fv, fa, fq);
		`CHK("frozen", {2'b00, mdl[5][15:0]}, {fv, fa, nid})
		ce = 1'b1;
		check_outs;
		do_reset;
		results;
	end
endmodule : test_switch_node_config_regs
